/* File: src/ist_pkg.sv */
package ist_pkg;
  localparam int ADDR_W = 7;
  localparam int HOLD_W = 8;
  localparam logic [7:0] GCALL_ADDR = 8'h00;
  localparam logic [HOLD_W-1:0] HOLD_RST = 8'h00;
  localparam logic [ADDR_W-1:0] OWN_RST = 7'h00;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100,
    ST_WAIT = 3'b101
  } ist_state_t;

  // Mode and address configuration as one group
  typedef struct packed {
    logic bus_enable_bit;
    logic irq_enable_bit;
    logic general_call_enable;
    logic ack_enable;
    logic [ADDR_W-1:0] own_address_field;
    logic [HOLD_W-1:0] sda_hold_count;
  } ist_cfg_t;

  // Event flags raised by the link side
  typedef struct packed {
    logic sel;
    logic done;
    logic stop;
  } ist_evt_t;
endpackage

/* File: src/ist_fifo.sv */
`timescale 1ns/1ns
module ist_fifo
  import ist_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest flags from the occupancy count
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Next pointers and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule

/* File: src/ist_slave_tx.sv */
`timescale 1ns/1ns
module ist_slave_tx
  import ist_pkg::*;
(
  // System clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link clock: the bus master's SCL edges, as a clock
  input wire logic scl_clk_i,
  // Configuration
  input wire ist_cfg_t cfg_i,
  // Transmit byte stream (data register writes)
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i,
  // Status register write strobe (any value)
  input wire logic status_wr_i,
  // Bus pins
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o,
  // Status flags (sel/done pulses, sticky stop), interrupt pulse, clock gate and busy levels
  output ist_evt_t status_o,
  output logic irq_o,
  output logic clk_gate_o,
  output logic busy_o
);
  // Peripheral clock gate and run condition
  logic run;
  assign run = cfg_i.bus_enable_bit && cfg_i.irq_enable_bit;

  // Transmit FIFO ahead of the shifter
  logic f_valid, f_ready, f_ready_q;
  logic [7:0] f_data;
  ist_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(f_ready),
    .in_data_i(tx_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready_q),
    .out_data_o(f_data)
  );
  assign tx_ready_o = f_ready;

  // Link pins synchronised into mclk; SCL is also sampled as data
  logic [SYNC_STAGES-1:0] sda_s_q, scl_s_q;
  logic sda_p_q, scl_p_q;
  logic sda_v, scl_v;
  assign sda_v = sda_s_q[1];
  assign scl_v = scl_s_q[1];
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_s_q <= '1;
      scl_s_q <= '1;
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_s_q <= {scl_s_q[0], scl_clk_i};
      sda_p_q <= sda_v;
      scl_p_q <= scl_v;
    end
  end

  // Link-domain activity toggle: flips on every SCL rising edge, never cleared per frame
  logic scl_tgl_q;
  always_ff @(posedge scl_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_tgl_q <= 1'b0;
    end else begin
      scl_tgl_q <= ~scl_tgl_q;
    end
  end
  logic [1:0] tgl_s_q;
  logic tgl_p_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s_q <= '0;
      tgl_p_q <= 1'b0;
    end else begin
      tgl_s_q <= {tgl_s_q[0], scl_tgl_q};
      tgl_p_q <= tgl_s_q[1];
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = (tgl_s_q[1] != tgl_p_q) && scl_v;
  assign scl_fall = scl_p_q && !scl_v;
  assign start_c = scl_v && scl_p_q && sda_p_q && !sda_v;
  assign stop_c = scl_v && scl_p_q && !sda_p_q && sda_v;

  // Address decode used in match and in the miss check; the own-address compare leaves the read bit to be tested apart
  function automatic logic addr_hit(input logic [7:0] b, input ist_cfg_t c);
    addr_hit = (b[7:1] == c.own_address_field) ||
               (c.general_call_enable && b == GCALL_ADDR);
  endfunction

  // Main sequencer state
  ist_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic hold_scl_q, hold_scl_d;
  logic nack_q, nack_d;
  logic stop_flag_q, stop_flag_d;
  // Selected since the last START or STOP; a nack release leaves us idle, STOP still counts
  logic sel_seen_q, sel_seen_d;
  ist_evt_t ev_q, ev_d;
  logic sda_q, sda_d, sda_oe_q, sda_oe_d;
  logic [HOLD_W-1:0] hcnt_q, hcnt_d;
  logic pend_q, pend_d, pend_oe_q, pend_oe_d, pend_val_q, pend_val_d;
  logic pop_d;

  // Next-state logic
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    hold_scl_d = hold_scl_q;
    nack_d = nack_q;
    stop_flag_d = stop_flag_q;
    sel_seen_d = sel_seen_q;
    ev_d = '0;
    sda_d = sda_q;
    sda_oe_d = sda_oe_q;
    hcnt_d = hcnt_q;
    pend_d = pend_q;
    pend_oe_d = pend_oe_q;
    pend_val_d = pend_val_q;
    pop_d = 1'b0;
    // SDA changes queued at an SCL fall wait out the programmed hold
    if (pend_q) begin
      if (hcnt_q == '0) begin
        sda_oe_d = pend_oe_q;
        sda_d = pend_val_q;
        pend_d = 1'b0;
      end else begin
        hcnt_d = hcnt_q - 1'b1;
      end
    end
    if (!run) begin
      st_d = ST_IDLE;
      sel_seen_d = 1'b0;
      hold_scl_d = 1'b0;
      sda_oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (stop_c && (st_q != ST_IDLE || sel_seen_q)) begin
      st_d = ST_IDLE;
      sel_seen_d = 1'b0;
      stop_flag_d = 1'b1;
      ev_d.stop = 1'b1;
      hold_scl_d = 1'b0;
      sda_oe_d = 1'b0;
      pend_d = 1'b0;
    end else if (start_c) begin
      st_d = ST_ADDR;
      sel_seen_d = 1'b0;
      bit_d = 3'h0;
      hold_scl_d = 1'b0;
      sda_oe_d = 1'b0;
      pend_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          sda_oe_d = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_v};
            bit_d = bit_q + 1'b1;
            if (bit_q == 3'h7) begin
              // Only a read request with a hit and ack enabled selects
              if (addr_hit({sh_q[6:0], sda_v}, cfg_i) && cfg_i.ack_enable &&
                  sda_v) begin
                st_d = ST_AACK;
              end else begin
                st_d = ST_IDLE;
              end
            end
          end
        end
        ST_AACK: begin
          // Drive ACK low after the eighth falling edge
          if (scl_fall && !hold_scl_q && !sda_oe_q && !pend_q) begin
            pend_d = 1'b1;
            pend_oe_d = 1'b1;
            pend_val_d = 1'b0;
            hcnt_d = cfg_i.sda_hold_count;
          end
          if (scl_rise && (sda_oe_q || pend_q)) begin
            // Ninth bit taken; stretch at next fall
            ev_d.sel = 1'b1;
            sel_seen_d = 1'b1;
            st_d = ST_WAIT;
            nack_d = 1'b0;
          end
        end
        ST_WAIT: begin
          if (scl_fall && !hold_scl_q) begin
            hold_scl_d = 1'b1;
            pend_d = 1'b1;
            pend_oe_d = 1'b0;
            pend_val_d = 1'b1;
            hcnt_d = cfg_i.sda_hold_count;
          end
          if (hold_scl_q && status_wr_i) begin
            hold_scl_d = 1'b0;
            stop_flag_d = 1'b0;
            if (nack_q) begin
              st_d = ST_IDLE;
            end else begin
              st_d = ST_SEND;
              sh_d = f_valid ? f_data : 8'hFF;
              pop_d = f_valid;
              bit_d = 3'h0;
              // First bit set with the SCL release: a later edge would read as START
              pend_d = 1'b0;
              sda_oe_d = !sh_d[7];
              sda_d = 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_q == 3'h7) begin
              st_d = ST_MACK;
              pend_d = 1'b1;
              pend_oe_d = 1'b0;
              pend_val_d = 1'b1;
            end else begin
              sh_d = {sh_q[6:0], 1'b1};
              bit_d = bit_q + 1'b1;
              pend_d = 1'b1;
              pend_oe_d = !sh_q[6];
              pend_val_d = 1'b0;
            end
            hcnt_d = cfg_i.sda_hold_count;
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nack_d = sda_v;
            ev_d.done = 1'b1;
            st_d = ST_WAIT;
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
    // Status write clears stop; a fresh stop wins the same cycle
    if (status_wr_i && !ev_d.stop) begin
      stop_flag_d = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      hold_scl_q <= 1'b0;
      nack_q <= 1'b0;
      stop_flag_q <= 1'b0;
      sel_seen_q <= 1'b0;
      ev_q <= '0;
      sda_q <= 1'b0;
      sda_oe_q <= 1'b0;
      hcnt_q <= HOLD_RST;
      pend_q <= 1'b0;
      pend_oe_q <= 1'b0;
      pend_val_q <= 1'b0;
      f_ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      hold_scl_q <= hold_scl_d;
      nack_q <= nack_d;
      stop_flag_q <= stop_flag_d;
      sel_seen_q <= sel_seen_d;
      ev_q <= ev_d;
      sda_q <= sda_d;
      sda_oe_q <= sda_oe_d;
      hcnt_q <= hcnt_d;
      pend_q <= pend_d;
      pend_oe_q <= pend_oe_d;
      pend_val_q <= pend_val_d;
      f_ready_q <= pop_d;
    end
  end

  // Output registers
  logic irq_q, gate_q, busy_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
      gate_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      irq_q <= ev_d.sel || ev_d.done || ev_d.stop;
      gate_q <= run;
      busy_q <= (st_d != ST_IDLE);
    end
  end
  assign sda_o = sda_q;
  assign sda_oe_o = sda_oe_q;
  assign scl_o = 1'b0 & hold_scl_q;
  assign scl_oe_o = hold_scl_q;
  assign status_o = '{sel: ev_q.sel, done: ev_q.done, stop: stop_flag_q};
  assign irq_o = irq_q;
  assign clk_gate_o = gate_q;
  assign busy_o = busy_q;

  // Checks
  idle_when_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !run |=> st_q == ST_IDLE)
    else $error("block active while disabled");
  release_on_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    hold_scl_q && status_wr_i && run && !start_c && !stop_c |=> !scl_oe_o)
    else $error("SCL not released after status write");
  stop_sets_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    stop_c && run && (st_q != ST_IDLE || sel_seen_q) |=> stop_flag_q && st_q == ST_IDLE)
    else $error("stop not flagged");
  start_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    start_c && run && !stop_c |=> st_q == ST_ADDR && bit_q == 3'h0)
    else $error("start did not restart address phase");
  sel_only_ack_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_q.sel |-> cfg_i.ack_enable)
    else $error("select raised with ack disabled");
  sel_irq_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(ev_q.sel) |-> irq_q)
    else $error("select without interrupt");
  done_then_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ev_q.done |-> st_q == ST_WAIT || st_q == ST_IDLE || st_q == ST_ADDR)
    else $error("byte done without stretch wait");
  nack_to_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_q == ST_WAIT && nack_q && hold_scl_q && status_wr_i && run && !start_c
    |=> st_q == ST_IDLE)
    else $error("nack did not end transfer");
  miss_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    st_q == ST_ADDR && st_d == ST_AACK |-> addr_hit(sh_d, cfg_i))
    else $error("selected on address miss");
  hold_wait_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pend_q && hcnt_q != '0 && run && !start_c && !stop_c |=> $stable(sda_oe_q))
    else $error("SDA moved before hold count");
  cov_sel_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ev_q.sel);
  cov_done_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ev_q.done);
  cov_stop_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(stop_flag_q));
endmodule

/* File: testbench/ist_master_model.sv */
`timescale 1ns/1ns
module ist_master_model
  import ist_pkg::*;
#(
  parameter int HALF = 100
) (
  // Link clock, 6 ns ticks
  input wire logic lclk_i,
  // Wired bus levels
  input wire logic scl_i,
  input wire logic sda_i,
  // Drives, 1 = released to the pull-up
  output logic scl_rel_o,
  output logic sda_rel_o,
  // Bytes read back from the slave
  output logic [7:0] rd_byte_o,
  output logic rd_stb_o
);
  // Idle bus: SCL stands high between frames
  initial begin
    scl_rel_o = 1'b1;
    sda_rel_o = 1'b1;
    rd_byte_o = 8'h00;
    rd_stb_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk_i);
  endtask

  // Release SCL and wait out a stretch; the bound keeps a stuck slave from hanging us
  task automatic rise();
    int k;
    k = 0;
    scl_rel_o = 1'b1;
    while (scl_i !== 1'b1 && k < 100000) begin
      @(posedge lclk_i);
      k++;
    end
    tick(HALF / 2);
  endtask

  // One clock pulse, SDA sampled in the middle of the high phase
  task automatic clk_bit(output logic b);
    tick(HALF);
    rise();
    b = sda_i;
    tick(HALF / 2);
    scl_rel_o = 1'b0;
  endtask

  // Also serves as repeated START when SCL is low
  task automatic start_cond();
    sda_rel_o = 1'b1;
    tick(HALF);
    rise();
    sda_rel_o = 1'b0;
    tick(HALF);
    scl_rel_o = 1'b0;
  endtask

  task automatic stop_cond();
    sda_rel_o = 1'b0;
    tick(HALF);
    rise();
    sda_rel_o = 1'b1;
    tick(HALF);
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_rel_o = v[i];
      clk_bit(b);
    end
    sda_rel_o = 1'b1;
    clk_bit(b);
    ack = ~b;
  endtask

  // Nack on the last byte tells the slave to wait for STOP or restart
  task automatic get_byte(input logic ack);
    logic [7:0] v;
    logic b;
    sda_rel_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b);
      v[i] = b;
    end
    sda_rel_o = ~ack;
    clk_bit(b);
    rd_byte_o = v;
    rd_stb_o = 1'b1;
    tick(1);
    rd_stb_o = 1'b0;
  endtask
endmodule

/* File: testbench/i2c_slave_transmitter_tb.sv */
`timescale 1ns/1ns
module i2c_slave_transmitter_tb
  import ist_pkg::*;
();
  logic mclk, lclk, rst_n, tx_valid, status_wr, tx_ready;
  logic [7:0] tx_data;
  ist_cfg_t cfg;
  ist_evt_t evt;
  logic sda_o, sda_oe, scl_o, scl_oe, irq, gate, busy;
  logic scl_rel, sda_rel, rd_stb;
  logic [7:0] rd_byte;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int tests_run = 0;
  int sel_n = 0;
  int done_n = 0;
  // Open-drain lines with pull-ups
  wire scl_w = scl_rel & (scl_o | ~scl_oe);
  wire sda_w = sda_rel & (sda_o | ~sda_oe);

  // System clock 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Link timebase, off phase from the system clock
  initial begin
    lclk = 1'b0;
    #7;
    forever #3 lclk = ~lclk;
  end

  ist_slave_tx DUT (.mclk_i(mclk), .rst_n_i(rst_n), .scl_clk_i(scl_w), .cfg_i(cfg),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
    .status_wr_i(status_wr), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .status_o(evt), .irq_o(irq),
    .clk_gate_o(gate), .busy_o(busy));
  ist_master_model mst (.lclk_i(lclk), .scl_i(scl_w), .sda_i(sda_w), .scl_rel_o(scl_rel),
    .sda_rel_o(sda_rel), .rd_byte_o(rd_byte), .rd_stb_o(rd_stb));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic check1(input string nm, input logic seen, input logic exp);
    check(nm, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic status_write();
    status_wr <= 1'b1;
    @(negedge mclk);
    status_wr <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Each byte the master reads is matched against the oldest note
  always @(posedge rd_stb) begin
    if (exp_q.size() == 0) begin
      check("note queue", 8'(exp_q.size()), 8'h01);
    end else begin
      check("read byte", rd_byte, exp_q.pop_front());
    end
  end

  // Firmware: stall a while on select or byte-done, then release SCL
  always @(negedge mclk) begin
    if (evt.sel === 1'b1 || evt.done === 1'b1) begin
      check1("irq", irq, 1'b1);
      if (evt.sel) begin
        sel_n++;
      end else begin
        done_n++;
      end
      repeat (40) @(negedge mclk);
      check1("stretch", scl_w, 1'b0);
      status_write();
    end
  end

  // Hang guard, well beyond the expected run of about 140 us
  initial begin
    #1000000;
    fail_count++;
    $display("ERROR watchdog expected end seen hang");
    wrap_up();
  end

  initial begin
    logic [7:0] v;
    logic a;
    v = 8'($urandom(51));
    rst_n = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    status_wr = 1'b0;
    cfg = '0;
    cfg.own_address_field = 7'($urandom_range(1, 127));
    cfg.sda_hold_count = 8'($urandom_range(0, 1));
    repeat (5) @(negedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check1("busy", busy, 1'b0);
    // Clock gate follows both enables
    for (int i = 0; i < 4; i++) begin
      cfg.bus_enable_bit <= i[0];
      cfg.irq_enable_bit <= i[1];
      repeat (3) @(negedge mclk);
      check1("gate", gate, i == 3);
    end
    // Refusals: disabled, wrong address, ack off, write bit
    for (int i = 0; i < 4; i++) begin
      cfg.ack_enable <= (i != 2);
      cfg.bus_enable_bit <= (i != 0);
      cfg.irq_enable_bit <= (i != 0);
      v = {cfg.own_address_field ^ 7'(i == 1), i != 3};
      @(negedge mclk);
      mst.start_cond();
      mst.put_byte(v, a);
      check1("refused ack", a, 1'b0);
      mst.stop_cond();
      check1("idle", busy, 1'b0);
    end
    status_write();
    // Fill the buffer until it refuses; the refused byte must never appear
    tx_valid <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      check1("room", tx_ready, 1'b1);
      v = 8'($urandom);
      tx_data <= v;
      exp_q.push_back(v);
      @(negedge mclk);
    end
    tx_data <= 8'h5A;
    repeat (3) @(negedge mclk);
    check1("full", tx_ready, 1'b0);
    tx_valid <= 1'b0;
    mst.start_cond();
    mst.put_byte({cfg.own_address_field, 1'b1}, a);
    check1("select ack", a, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      mst.get_byte(i < FIFO_DEPTH - 1);
    end
    // Drained buffer sends all ones after a repeated START
    exp_q.push_back(8'hFF);
    mst.start_cond();
    mst.put_byte({cfg.own_address_field, 1'b1}, a);
    check1("reselect ack", a, 1'b1);
    mst.get_byte(1'b0);
    mst.stop_cond();
    for (int k = 0; k < 100 && evt.stop !== 1'b1; k++) begin
      @(negedge mclk);
    end
    repeat (5) @(negedge mclk);
    check1("stop flag", evt.stop, 1'b1);
    status_write();
    repeat (3) @(negedge mclk);
    check1("stop clear", evt.stop, 1'b0);
    check1("idle", busy, 1'b0);
    check("sel count", 8'(sel_n), 8'h02);
    check("done count", 8'(done_n), 8'h05);
    check("notes left", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule
